//--- shared/clcd_consts.svh
// constants for the character display controller: timing counts and encodings
`ifndef CLCD_CONSTS_SVH
`define CLCD_CONSTS_SVH
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLCD_CLK_PERIOD_NS 10
`define CLCD_EXEC_TIME_NS 37000
`define CLCD_EXEC_CYC ((`CLCD_EXEC_TIME_NS + `CLCD_CLK_PERIOD_NS - 1) / `CLCD_CLK_PERIOD_NS)
// ------------------------------------------------------------
// instruction fields and reset values
// ------------------------------------------------------------
`define CLCD_BIT_SET_TEXT_ADDR 7
`define CLCD_BIT_SET_GLYPH_ADDR 6
`define CLCD_BIT_FUNC_SET 5
`define CLCD_BIT_WIDTH_SEL 4
`define CLCD_BIT_TWO_LINE 3
`define CLCD_BIT_TALL 2
`define CLCD_BIT_DISP_CTRL 3
`define CLCD_BIT_DISP_ON 2
`define CLCD_BIT_CUR_ON 1
`define CLCD_BIT_BLINK_ON 0
`define CLCD_RST_WIDTH8 1'b1
`define CLCD_LINE2_BASE 7'h40
`define CLCD_CUR_ROW_SHORT 4'h7
`define CLCD_CUR_ROW_TALL 4'ha
`define CLCD_ROWS_ONE_SHORT 5'h08
`define CLCD_ROWS_ONE_TALL 5'h0b
`define CLCD_ROWS_TWO 5'h10
`endif

//--- shared/clcd_pkg.sv
// types shared by the character display controller files
`default_nettype none
package clcd_pkg;
  // one queued host byte: instruction or data
  typedef struct packed {
    logic is_data; // high for a data byte
    logic [7:0] value; // the byte itself
  } clcd_req_s;
  // programmed display configuration
  typedef struct packed {
    logic width8; // interface_width_select
    logic two_line; // two text lines
    logic tall; // 5x10 glyphs
    logic disp_on; // display on
    logic cur_on; // cursor on
    logic blink_on; // blinking on
  } clcd_cfg_s;
  typedef enum logic [0:0] {CLCD_EX_IDLE, CLCD_EX_WAIT} clcd_exec_e;
endpackage : clcd_pkg
`default_nettype wire

//--- core/clcd_fifo.sv
// parameterised valid/ready fifo for queued host bytes
`default_nettype none
module clcd_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic in_valid, // write request
  output logic in_ready, // room available
  input wire logic [W-1:0] in_data, // write word
  output logic out_valid, // word available
  input wire logic out_ready, // drain accepts
  output logic [W-1:0] out_data // head word
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D]; // storage
  logic [AW-1:0] wr_q; // write pointer
  logic [AW-1:0] rd_q; // read pointer
  logic [AW:0] cnt_q; // fill level
  logic push;
  logic pop;
  assign in_ready = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_q];
  // ------------------------------------------------------------
  // storage and pointers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
    end
  end
  // level moves only on an unmatched push or pop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (push && !pop) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule : clcd_fifo
`default_nettype wire

//--- core/clcd_glyph_map.sv
// maps a character code and glyph row to a user glyph ram address
`default_nettype none
module clcd_glyph_map (
  input wire logic [7:0] code, // character code from text ram
  input wire logic [3:0] grow, // pattern line within the glyph
  input wire logic tall, // 5x10 glyph mode
  output logic [5:0] ugr_addr, // user glyph ram address
  output logic use_ugr // code selects a user glyph
);
  // ------------------------------------------------------------
  // address build
  // ------------------------------------------------------------
  // tall glyphs drop code bits 0 and 3, so four codes alias
  assign use_ugr = (code[7:4] == 4'h0);
  always_comb begin
    if (tall) begin
      ugr_addr = {code[2:1], grow};
    end else begin
      ugr_addr = {code[2:0], grow[2:0]};
    end
  end
endmodule : clcd_glyph_map
`default_nettype wire

//--- core/clcd_top.sv
// character display controller: host port, command queue, refresh and drivers
`include "clcd_consts.svh"
`default_nettype none
// Summary of operation
// - tall mode: code bits 2:1 pick glyph
// - tall mode: address bits 3:0 pick line
// - tall mode: eleventh line, else eighth, ORs stored dots with cursor
// - lines twelve to sixteen never displayed
// - code bits 7:4 zero selects user glyphs
// - stored one lights dot, zero dark
// - dot bit 4 is leftmost, bits 0-4
// - refresh reads independent of host accesses
// - sixteen commons, forty segments, needed ones driven
// - unneeded commons held at non-selection
// - serial transfer starts at last address
// - latch when starting address pattern arrives
// - cursor shown where address equals counter
// - 4-bit mode uses upper lines only
// - two nibbles per byte, high first
// - 8-bit mode moves byte per transfer
// - width chosen by function configuration bit
// - while busy writes dropped, busy and data reads both answered
module clcd_top #(
  parameter int NCHAR = 8, // characters per segment chain
  parameter int QDEPTH = 16, // queued host bytes
  parameter int BLINK_FRAMES = 32 // frames per blink half period
) (
  input wire logic clk_sys, // system clock, 100 MHz
  input wire logic rst_b, // reset, active low, async
  input wire logic host_rs, // register select pin
  input wire logic host_rw, // read high, write low
  input wire logic host_e, // enable strobe pin
  input wire logic [7:0] host_db_i, // data lines in
  output logic [7:0] host_db_o, // data lines out
  output logic host_db_oe, // high while driving data lines
  output logic [15:0] com_o, // common select, high = selected
  output logic [39:0] seg_o // segment dots, high = lit
);
  import clcd_pkg::*;
  localparam logic [11:0] EXEC_CYC = 12'(`CLCD_EXEC_CYC);
  localparam int CW = $clog2(NCHAR);
  // ------------------------------------------------------------
  // reset and pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] rst_sync_q; // reset release chain
  logic rst_n; // synchronised reset
  logic [10:0] pin_s1_q; // first stage, read only by second
  logic [10:0] pin_s2_q; // second stage
  logic e_prev_q; // last stage enable for edges
  logic rs_s, rw_s, e_s;
  logic [7:0] db_s;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];
  // pins are asynchronous to clk_sys
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      e_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= {host_rs, host_rw, host_e, host_db_i};
      pin_s2_q <= pin_s1_q;
      e_prev_q <= pin_s2_q[8];
    end
  end
  assign {rs_s, rw_s, e_s, db_s} = pin_s2_q;
  logic e_rise, e_fall, nib_strobe, wr_strobe;
  assign e_rise = e_s && !e_prev_q;
  assign e_fall = !e_s && e_prev_q;
  assign nib_strobe = e_fall;
  assign wr_strobe = e_fall && !rw_s;
  // ------------------------------------------------------------
  // configuration and state
  // ------------------------------------------------------------
  clcd_cfg_s cfg_q; // programmed configuration
  logic [6:0] ac_q; // cursor_address_counter
  logic sel_glyph_q; // data bytes target user glyph ram
  logic phase_q; // nibble phase, 1 = low nibble next
  logic [3:0] hi_nib_q; // held high nibble of a write
  logic [7:0] rd_byte_q; // byte being read out
  logic internal_op_pending; // busy: queue cannot take a byte
  logic [7:0] text_ram [128]; // display_text_ram
  logic [7:0] glyph_ram [64]; // user_glyph_ram
  // ------------------------------------------------------------
  // host write path into the queue
  // ------------------------------------------------------------
  clcd_req_s push_req;
  clcd_req_s head_req;
  logic push_valid, q_ready, q_valid, q_pop;
  always_comb begin
    push_req.is_data = rs_s;
    if (cfg_q.width8) begin
      push_req.value = db_s;
      push_valid = wr_strobe;
    end else begin
      push_req.value = {hi_nib_q, db_s[7:4]};
      push_valid = wr_strobe && phase_q;
    end
  end
  // a full queue is the busy condition; bytes arriving then are dropped
  assign internal_op_pending = !q_ready;
  clcd_fifo #(.W($bits(clcd_req_s)), .D(QDEPTH)) u_queue (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_ready(q_ready),
    .in_data(push_req),
    .out_valid(q_valid),
    .out_ready(q_pop),
    .out_data(head_req)
  );
  // high nibble held until its partner arrives; lower lines ignored
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) hi_nib_q <= 4'h0;
    else if (wr_strobe && !phase_q) hi_nib_q <= db_s[7:4];
  end
  // nibble phase restarts at high when 4-bit mode is entered
  logic width8_prev_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 1'b0;
      width8_prev_q <= `CLCD_RST_WIDTH8;
    end else begin
      width8_prev_q <= cfg_q.width8;
      if (cfg_q.width8 || width8_prev_q) phase_q <= 1'b0;
      else if (nib_strobe) phase_q <= !phase_q;
    end
  end
  // ------------------------------------------------------------
  // host read path
  // ------------------------------------------------------------
  // byte captured at the rise of the first strobe of a read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_byte_q <= 8'h00;
    end else if (e_rise && rw_s && (cfg_q.width8 || !phase_q)) begin
      if (rs_s) rd_byte_q <= sel_glyph_q ? glyph_ram[ac_q[5:0]] : text_ram[ac_q];
      else rd_byte_q <= {internal_op_pending, ac_q};
    end
  end
  // drive lines while enable is high during a read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      host_db_oe <= 1'b0;
      host_db_o <= 8'h00;
    end else begin
      host_db_oe <= e_s && rw_s && !e_rise;
      if (cfg_q.width8) host_db_o <= rd_byte_q;
      else if (!phase_q) host_db_o <= {rd_byte_q[7:4], 4'h0};
      else host_db_o <= {rd_byte_q[3:0], 4'h0};
    end
  end
  // ------------------------------------------------------------
  // instruction execution, one queued byte per execution time
  // ------------------------------------------------------------
  clcd_exec_e ex_q;
  logic [11:0] ex_cnt_q; // cycles left in current operation
  assign q_pop = (ex_q == CLCD_EX_IDLE) && q_valid;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ex_q <= CLCD_EX_IDLE;
      ex_cnt_q <= 12'h000;
    end else begin
      unique case (ex_q)
        CLCD_EX_IDLE: if (q_pop) begin
          ex_q <= CLCD_EX_WAIT;
          ex_cnt_q <= EXEC_CYC - 12'h001;
        end
        CLCD_EX_WAIT: if (ex_cnt_q == 12'h000) begin
          ex_q <= CLCD_EX_IDLE;
        end else begin
          ex_cnt_q <= ex_cnt_q - 12'h001;
        end
      endcase
    end
  end
  // configuration instructions; clear, home and shift are not handled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= '{width8: `CLCD_RST_WIDTH8, default: 1'b0};
      ac_q <= 7'h00;
      sel_glyph_q <= 1'b0;
    end else if (q_pop) begin
      if (head_req.is_data) begin
        ac_q <= sel_glyph_q ? {1'b0, ac_q[5:0] + 6'h01} : ac_q + 7'h01;
      end else if (head_req.value[`CLCD_BIT_SET_TEXT_ADDR]) begin
        ac_q <= head_req.value[6:0];
        sel_glyph_q <= 1'b0;
      end else if (head_req.value[`CLCD_BIT_SET_GLYPH_ADDR]) begin
        ac_q <= {1'b0, head_req.value[5:0]};
        sel_glyph_q <= 1'b1;
      end else if (head_req.value[`CLCD_BIT_FUNC_SET]) begin
        cfg_q.width8 <= head_req.value[`CLCD_BIT_WIDTH_SEL];
        cfg_q.two_line <= head_req.value[`CLCD_BIT_TWO_LINE];
        cfg_q.tall <= head_req.value[`CLCD_BIT_TALL];
      end else if (head_req.value[`CLCD_BIT_DISP_CTRL]) begin
        cfg_q.disp_on <= head_req.value[`CLCD_BIT_DISP_ON];
        cfg_q.cur_on <= head_req.value[`CLCD_BIT_CUR_ON];
        cfg_q.blink_on <= head_req.value[`CLCD_BIT_BLINK_ON];
      end
    end
  end
  // ram writes; unshown glyph lines stay plain storage
  always_ff @(posedge clk_sys) begin
    if (q_pop && head_req.is_data) begin
      if (sel_glyph_q) glyph_ram[ac_q[5:0]] <= head_req.value;
      else text_ram[ac_q] <= head_req.value;
    end
  end
  // ------------------------------------------------------------
  // display refresh: own read ports, never waits on host
  // ------------------------------------------------------------
  function automatic logic [4:0] rows_used(input clcd_cfg_s c);
    if (c.two_line) return `CLCD_ROWS_TWO;
    else if (c.tall) return `CLCD_ROWS_ONE_TALL;
    else return `CLCD_ROWS_ONE_SHORT;
  endfunction : rows_used
  logic [CW-1:0] chr_q; // character in transfer, counts down
  logic [3:0] row_q; // common being built
  logic [4:0] frame_q; // frames since blink toggle
  logic blink_ph_q; // blink phase, 1 = cursor cell all lit
  logic [39:0] sh_q; // segment shift chain
  logic [39:0] sh_d;
  logic latch;
  logic tall_eff;
  logic [3:0] grow, cur_row;
  logic [6:0] taddr;
  logic [7:0] code;
  logic [5:0] gaddr;
  logic use_ugr, at_cur;
  logic [4:0] dots;
  assign tall_eff = cfg_q.tall && !cfg_q.two_line;
  assign grow = cfg_q.two_line ? {1'b0, row_q[2:0]} : row_q;
  assign cur_row = tall_eff ? `CLCD_CUR_ROW_TALL : `CLCD_CUR_ROW_SHORT;
  assign taddr = ((cfg_q.two_line && row_q[3]) ? `CLCD_LINE2_BASE : 7'h00) + 7'(chr_q);
  assign code = text_ram[taddr];
  assign at_cur = (taddr == ac_q) && !sel_glyph_q;
  clcd_glyph_map u_map (
    .code(code),
    .grow(grow),
    .tall(tall_eff),
    .ugr_addr(gaddr),
    .use_ugr(use_ugr)
  );
  // the builtin glyph rom is not held here; a fixed code-derived row stands in
  always_comb begin
    if (!cfg_q.disp_on) dots = 5'h00;
    else if (cfg_q.blink_on && at_cur && blink_ph_q) dots = 5'h1f;
    else begin
      dots = use_ugr ? glyph_ram[gaddr][4:0] : code[4:0];
      if (cfg_q.cur_on && at_cur && (grow == cur_row)) dots = dots | 5'h1f;
    end
  end
  assign sh_d = {sh_q[34:0], dots};
  assign latch = (chr_q == '0);
  // transfer order: last address first, so the first one lands at the low end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chr_q <= CW'(NCHAR-1);
      sh_q <= '0;
    end else begin
      sh_q <= sh_d;
      chr_q <= latch ? CW'(NCHAR-1) : chr_q - 1'b1;
    end
  end
  // row scan wraps at the rows this configuration needs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      row_q <= 4'h0;
      frame_q <= 5'h00;
      blink_ph_q <= 1'b0;
    end else if (latch) begin
      if ({1'b0, row_q} >= rows_used(cfg_q) - 5'h01) begin
        row_q <= 4'h0;
        frame_q <= (frame_q == 5'(BLINK_FRAMES-1)) ? 5'h00 : frame_q + 5'h01;
        if (frame_q == 5'(BLINK_FRAMES-1)) blink_ph_q <= !blink_ph_q;
      end else begin
        row_q <= row_q + 4'h1;
      end
    end
  end
  // drivers update together once the first position is shifted in
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seg_o <= 40'h0;
      com_o <= 16'h0;
    end else if (latch) begin
      seg_o <= sh_d;
      com_o <= ({1'b0, row_q} < rows_used(cfg_q)) ? 16'h1 << row_q : 16'h0;
    end
  end
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_hi_nib;
    nib_strobe && !phase_q && !cfg_q.width8 && !width8_prev_q;
  endsequence
  sequence s_lo_nib;
    wr_strobe && phase_q && !cfg_q.width8 && q_ready;
  endsequence
  property p_hi_then_lo;
    s_hi_nib |=> phase_q;
  endproperty
  property p_lo_pushes;
    s_lo_nib |-> push_valid && push_req.value == {hi_nib_q, db_s[7:4]};
  endproperty
  a_nib_phase_step: assert property (p_hi_then_lo) else $error("phase did not move to low");
  a_nib_byte_order: assert property (p_lo_pushes) else $error("byte not high nibble first");
  a_no_push_hi_nib: assert property (s_hi_nib |-> !push_valid) else $error("high nibble pushed");
  // a full queue may still drain, so the level can only hold or fall
  a_busy_refused: assert property (wr_strobe && !q_ready |=> u_queue.cnt_q <= $past(u_queue.cnt_q))
    else $error("write taken while busy");
  a_exec_spacing: assert property (q_pop |=> !q_pop [*8]) else $error("operations too close");
  // text ram has no reset, so map checks wait until the display is switched on
  a_tall_map: assert property (tall_eff && cfg_q.disp_on |-> gaddr == {code[2:1], grow})
    else $error("tall map wrong");
  a_ugr_select: assert property (cfg_q.disp_on |-> use_ugr == (code[7:4] == 4'h0))
    else $error("user glyph select wrong");
  // cursor line lights every dot whatever is stored
  a_cursor_or: assert property (cfg_q.disp_on && cfg_q.cur_on && at_cur && grow == cur_row |-> dots == 5'h1f)
    else $error("cursor line not lit");
  a_last_first: assert property (latch |=> chr_q == CW'(NCHAR-1)) else $error("transfer not from last");
  a_latch_seg: assert property (latch |=> seg_o == sh_q) else $error("segments not latched");
  a_one_common: assert property ($onehot0(com_o)) else $error("several commons selected");
  // compare only when the configuration held across the latch
  a_unused_com: assert property ($past(latch) && $stable(cfg_q) |-> (com_o >> rows_used(cfg_q)) == 16'h0)
    else $error("unneeded common driven");
  // the held nibble must be the one on the upper lines at the first strobe
  a_hi_nib_take: assert property (wr_strobe && !phase_q |=> hi_nib_q == $past(db_s[7:4]))
    else $error("high nibble not held");
  // wide mode keeps the phase at high so a later switch starts cleanly
  a_phase_wide: assert property (cfg_q.width8 |=> !phase_q) else $error("phase moved in wide mode");
  // lines are driven only after a read strobe has been seen
  a_oe_on_read: assert property (host_db_oe |-> $past(e_s) && $past(rw_s)) else $error("lines driven off a read");
endmodule : clcd_top
`default_nettype wire

//--- test/clcd_host_model.sv
// host microprocessor model that drives the parallel display port
`default_nettype none
module clcd_host_model (
  input wire logic clk_sys, // system clock
  input wire logic [7:0] dev_db_o, // device data out
  input wire logic dev_db_oe, // device drives lines
  output logic host_rs, // register select
  output logic host_rw, // read high, write low
  output logic host_e, // enable strobe
  output logic [7:0] host_db // resolved data lines
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // bus state
  // ----------------------------------------
  logic [7:0] drv_q; // value the host puts out
  logic drv_en; // host drives the lines
  logic [7:0] last_q; // last value seen on the wire
  logic four_bit; // host view of the port width
  initial begin
    host_rs = 1'b0;
    host_rw = 1'b0;
    host_e = 1'b0;
    drv_q = 8'h00;
    drv_en = 1'b0;
    last_q = 8'h00;
    four_bit = 1'b0;
  end
  // released lines show the inverse of the last value, so a stale read cannot pass
  always @(posedge clk_sys) begin
    if (drv_en || dev_db_oe) begin
      last_q <= host_db;
    end
  end
  assign host_db = dev_db_oe ? dev_db_o : (drv_en ? drv_q : ~last_q);
  // ----------------------------------------
  // one enable strobe, held long enough for the synchronisers
  // ----------------------------------------
  task automatic strobe(input logic rs, input logic rw, input logic [7:0] wr, output logic [7:0] rd);
    @(posedge clk_sys);
    host_rs <= rs;
    host_rw <= rw;
    drv_q <= wr;
    drv_en <= !rw;
    @(posedge clk_sys);
    host_e <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rd = host_db;
    host_e <= 1'b0;
    repeat (6) @(posedge clk_sys);
    drv_en <= 1'b0;
  endtask : strobe
  // byte write: two nibbles, high first, or one byte
  task automatic put_byte(input logic rs, input logic [7:0] b);
    logic [7:0] unused;
    if (four_bit) begin
      strobe(rs, 1'b0, {b[7:4], ~b[7:4]}, unused);
      strobe(rs, 1'b0, {b[3:0], ~b[3:0]}, unused);
    end else begin
      strobe(rs, 1'b0, b, unused);
    end
  endtask : put_byte
  // byte read: busy and counter, or data, come as two nibble reads in narrow mode, high first
  task automatic get_byte(input logic rs, output logic [7:0] b);
    logic [7:0] hi;
    logic [7:0] lo;
    if (four_bit) begin
      strobe(rs, 1'b1, 8'h00, hi);
      strobe(rs, 1'b1, 8'h00, lo);
      b = {hi[7:4], lo[7:4]};
    end else begin
      strobe(rs, 1'b1, 8'h00, b);
    end
  endtask : get_byte
endmodule : clcd_host_model
`default_nettype wire

//--- test/clcd_top_tb_top.sv
// self-checking testbench for the character display controller
`default_nettype none
module clcd_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys; // 100 MHz clock
  logic rst_b; // reset, active low
  logic host_rs; // register select
  logic host_rw; // read high
  logic host_e; // enable strobe
  logic [7:0] host_db; // resolved data lines
  logic [7:0] host_db_o; // device data out
  logic host_db_oe; // device drives lines
  logic [15:0] com_o; // common selects
  logic [39:0] seg_o; // segment dots
  int err_count; // mismatches
  int checks; // comparisons made
  logic [7:0] rd; // byte read back
  // ----------------------------------------
  // clock, design and host
  // ----------------------------------------
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;
  // two characters per chain, so every shown text cell is written within the run
  clcd_top #(.NCHAR(2), .QDEPTH(16), .BLINK_FRAMES(2)) DUT (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .host_rs(host_rs),
    .host_rw(host_rw),
    .host_e(host_e),
    .host_db_i(host_db),
    .host_db_o(host_db_o),
    .host_db_oe(host_db_oe),
    .com_o(com_o),
    .seg_o(seg_o)
  );
  clcd_host_model host (
    .clk_sys(clk_sys),
    .dev_db_o(host_db_o),
    .dev_db_oe(host_db_oe),
    .host_rs(host_rs),
    .host_rw(host_rw),
    .host_e(host_e),
    .host_db(host_db)
  );
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  // each queued operation takes 3700 cycles once popped
  task automatic settle(input int n);
    repeat (n * 3710) @(posedge clk_sys);
  endtask : settle
  // stored glyph row pattern, bit 4 set on some rows
  function automatic logic [4:0] pat(input int r);
    return 5'((r * 7 + 1) % 32);
  endfunction : pat
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // full-width port: address set then status read in one transfer
  task automatic t_width8();
    host.put_byte(1'b0, 8'h88);
    settle(1);
    host.get_byte(1'b0, rd);
    check(40'(rd), 40'h08, "status in 8-bit mode");
    // a blank at address 1 keeps the cursor character defined
    host.put_byte(1'b0, 8'h81);
    host.put_byte(1'b1, 8'h20);
    host.put_byte(1'b0, 8'h20);
    settle(3);
    host.four_bit = 1'b1;
  endtask : t_width8
  // narrow port: junk on the low lines must be ignored, phase must start high
  task automatic t_width4();
    host.put_byte(1'b0, 8'h85);
    settle(1);
    host.get_byte(1'b0, rd);
    check(40'(rd), 40'h05, "status in 4-bit mode");
  endtask : t_width4
  // tall glyph: 17 unchecked bytes fill the queue, an 18th is dropped, then the frame is scanned
  task automatic t_glyph();
    logic [4:0] got0 [0:10];
    logic [4:0] cur1;
    logic [4:0] cur0;
    logic [10:0] seen;
    logic upper;
    int idx;
    int n;
    host.put_byte(1'b0, 8'h24);
    host.put_byte(1'b0, 8'h50);
    for (int r = 0; r < 11; r++) begin
      host.put_byte(1'b1, {3'h0, pat(r)});
    end
    host.put_byte(1'b1, 8'h1f);
    host.put_byte(1'b0, 8'h80);
    host.put_byte(1'b1, 8'h0b);
    host.put_byte(1'b0, 8'h0e);
    host.get_byte(1'b0, rd);
    check(40'(rd), 40'h85, "busy with full queue");
    // a byte sent while busy must be dropped, so the counter stays put
    host.put_byte(1'b1, 8'hff);
    settle(17);
    host.get_byte(1'b0, rd);
    check(40'(rd), 40'h01, "idle status after drain");
    seen = 11'h000;
    upper = 1'b0;
    cur1 = 5'h00;
    cur0 = 5'h1f;
    n = 0;
    while (seen !== 11'h7ff && n < 1000) begin
      @(posedge clk_sys);
      #1;
      n++;
      upper = upper | (|com_o[15:11]);
      idx = -1;
      for (int i = 0; i < 11; i++) begin
        if (com_o[i] === 1'b1 && $onehot(com_o)) begin
          idx = i;
        end
      end
      if (idx >= 0) begin
        seen[idx] = 1'b1;
        got0[idx] = seg_o[4:0];
        if (idx == 10) begin
          cur1 = seg_o[9:5];
        end
        if (idx == 0) begin
          cur0 = seg_o[9:5];
        end
      end
    end
    if (n >= 1000) begin
      err_count++;
      $display("MISMATCH t=%0t frame scan timed out", $time);
      return;
    end
    check(40'(seen), 40'h7ff, "rows driven");
    check(40'(upper), 40'h0, "unused commons quiet");
    for (int r = 0; r < 11; r++) begin
      check(40'(got0[r]), 40'(pat(r)), "aliased user glyph row");
    end
    check(40'(got0[10]), 40'h07, "stored cursor row shows without cursor");
    check(40'(cur1), 40'h1f, "cursor at counter position");
    check(40'(cur0), 40'h00, "cursor only on its line");
  endtask : t_glyph
  // blinking: the cursor character must show both lit and dark on a plain line
  task automatic t_blink();
    logic lit;
    logic dark;
    int n;
    host.put_byte(1'b0, 8'h0f);
    settle(1);
    lit = 1'b0;
    dark = 1'b0;
    for (n = 0; n < 200; n++) begin
      @(posedge clk_sys);
      #1;
      if (com_o === 16'h0001) begin
        lit = lit | (seg_o[9:5] === 5'h1f);
        dark = dark | (seg_o[9:5] === 5'h00);
      end
    end
    check(40'({lit, dark}), 40'h3, "cursor character blinks");
  endtask : t_blink
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    err_count = 0;
    checks = 0;
    rst_b = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check({com_o, host_db_oe}, 17'h0, "commons idle after reset");
    check(seg_o, 40'h0, "segments dark after reset");
    repeat (4) @(posedge clk_sys);
    t_width8();
    t_width4();
    t_glyph();
    t_blink();
    results();
  end
endmodule : clcd_top_tb_top
`default_nettype wire
